// File: hw/sit_pkg.sv
// Package for the sixteen-bit interval timer: control word layout, reset values, prescale codes.
// Assumes a single 100 MHz instruction-cycle clock domain.
package sit_pkg;
  localparam int unsigned SIT_COUNT_W = 16;
  localparam int unsigned SIT_PRE_W = 8;
  localparam logic [15:0] SIT_PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] SIT_COUNT_RST = 16'h0000;
  localparam logic [15:0] SIT_COUNT_STEP = 16'h0001;
  localparam logic [7:0] SIT_PRE_RST = 8'h00;
  localparam logic [7:0] SIT_PRE_STEP = 8'h01;
  localparam logic [7:0] SIT_PRE_LAST_1 = 8'h00;
  localparam logic [7:0] SIT_PRE_LAST_8 = 8'h07;
  localparam logic [7:0] SIT_PRE_LAST_64 = 8'h3F;
  localparam logic [7:0] SIT_PRE_LAST_256 = 8'hFF;

  typedef enum logic [1:0] {
    SIT_DIV1 = 2'b00,
    SIT_DIV8 = 2'b01,
    SIT_DIV64 = 2'b10,
    SIT_DIV256 = 2'b11
  } sit_prescale_t;

  // Control word fields as software sees them
  typedef struct packed {
    logic timerOnBit;
    logic idleStopBit;
    logic gateAccumulateEnable;
    sit_prescale_t prescaleSelect;
    logic externalSyncSelect;
    logic clockSourceSelect;
  } sit_ctrl_t;

  localparam sit_ctrl_t SIT_CTRL_RST = '{1'b0, 1'b0, 1'b0, SIT_DIV1, 1'b0, 1'b0};

  // Processor power state
  typedef struct packed {
    logic idle;
    logic sleep;
  } sit_power_t;
endpackage

// File: hw/sit_sync2.sv
// Two-flop synchroniser for a pin level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module sit_sync2
  import sit_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic stage1_r;

  // Runs without the clock enable so the pin is never seen unsynchronised
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// File: hw/sit_timer.sv
// Sixteen-bit interval timer/counter with prescaler, gate accumulation and idle/sleep control.
// Assumes one clock (instruction cycle); the external pin is sampled through two flip-flops.
`timescale 1ns/10ps
`default_nettype none
module sit_timer
  import sit_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire sit_ctrl_t ctrlWr,
  input wire logic ctrlWrEn,
  input wire logic [15:0] countWr,
  input wire logic countWrEn,
  input wire logic [15:0] periodWr,
  input wire logic periodWrEn,
  input wire logic flagClr,
  input wire sit_power_t power,
  input wire logic externalClockGatePin,
  output sit_ctrl_t ctrlRd,
  output logic [15:0] countValue,
  output logic [15:0] periodValue,
  output logic periodMatchFlag,
  output logic irqPulse
);
  sit_ctrl_t ctrl_r;
  logic [15:0] count_r;
  logic [15:0] period_r;
  logic [7:0] pre_r;
  logic [7:0] preLast;
  logic flag_r;
  logic irq_r;
  logic pinSync;
  logic pinPrev_r;
  logic rawTick;
  logic runOk;
  logic preTick;
  logic match;
  logic gateFall;
  logic onFall;

  sit_sync2 u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(externalClockGatePin),
    .dout(pinSync)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pinPrev_r <= 1'b0;
    else if (clkEn)
      pinPrev_r <= pinSync;
  end

  // Single clock domain: the asynchronous path is modelled as edge counting on the
  // synchronised pin too, so it differs from the synchronous one only in sleep
  // behaviour. Edges closer than two cycles are not resolved.
  always_comb
  begin
    if (!ctrl_r.clockSourceSelect)
      rawTick = ctrl_r.gateAccumulateEnable ? pinSync : 1'b1;
    else
      rawTick = pinSync & ~pinPrev_r;
  end

  // Idle and sleep gating
  always_comb
  begin
    runOk = ctrl_r.timerOnBit;
    if (power.idle && ctrl_r.idleStopBit)
      runOk = 1'b0;
    if (power.sleep && !(ctrl_r.clockSourceSelect && !ctrl_r.externalSyncSelect))
      runOk = 1'b0;
  end

  always_comb
  begin
    case (ctrl_r.prescaleSelect)
      SIT_DIV1: preLast = SIT_PRE_LAST_1;
      SIT_DIV8: preLast = SIT_PRE_LAST_8;
      SIT_DIV64: preLast = SIT_PRE_LAST_64;
      SIT_DIV256: preLast = SIT_PRE_LAST_256;
      default: preLast = SIT_PRE_LAST_1;
    endcase
  end

  assign preTick = runOk && rawTick && (pre_r >= preLast);
  assign match = (count_r == period_r);
  assign onFall = ctrlWrEn && ctrl_r.timerOnBit && !ctrlWr.timerOnBit;
  assign gateFall = ctrl_r.timerOnBit && ctrl_r.gateAccumulateEnable
    && !ctrl_r.clockSourceSelect && pinPrev_r && !pinSync;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_r <= SIT_CTRL_RST;
    else if (clkEn && ctrlWrEn)
      ctrl_r <= ctrlWr;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      period_r <= SIT_PERIOD_RST;
    else if (clkEn && periodWrEn)
      period_r <= periodWr;
  end

  // Prescaler: cleared on count write or timer-on clearing; frozen while disabled
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pre_r <= SIT_PRE_RST;
    else if (clkEn)
    begin
      if (countWrEn || onFall)
        pre_r <= SIT_PRE_RST;
      else if (runOk && rawTick)
        pre_r <= (pre_r >= preLast) ? SIT_PRE_RST : pre_r + SIT_PRE_STEP;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count_r <= SIT_COUNT_RST;
    else if (clkEn)
    begin
      if (countWrEn)
        count_r <= countWr;
      else if (preTick)
        count_r <= match ? SIT_COUNT_RST : count_r + SIT_COUNT_STEP;
    end
  end

  // Set wins over a same-cycle software clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_r <= 1'b0;
    else if (clkEn)
    begin
      if ((preTick && match) || gateFall)
        flag_r <= 1'b1;
      else if (flagClr)
        flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_r <= 1'b0;
    else if (clkEn)
      irq_r <= (preTick && match) || gateFall;
    else
      irq_r <= 1'b0;
  end

  assign ctrlRd = ctrl_r;
  assign countValue = count_r;
  assign periodValue = period_r;
  assign periodMatchFlag = flag_r;
  assign irqPulse = irq_r;

  chk_match_wraps: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && preTick && match && !countWrEn |=> count_r == SIT_COUNT_RST)
    else $error("count did not wrap after period match");

  chk_idle_stop_hold: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && power.idle && ctrl_r.idleStopBit && !countWrEn |=> $stable(count_r))
    else $error("count moved during idle with idle-stop set");

  chk_sleep_sync_hold: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && power.sleep && !ctrl_r.clockSourceSelect && !countWrEn |=> $stable(count_r))
    else $error("count moved in sleep on internal clock");

  chk_gate_low_hold: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && ctrl_r.gateAccumulateEnable && !ctrl_r.clockSourceSelect && !pinSync
    && !countWrEn |=> $stable(count_r))
    else $error("gated count moved with gate low");

  chk_count_write: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && countWrEn |=> count_r == $past(countWr) && pre_r == SIT_PRE_RST)
    else $error("count write not applied or prescaler not cleared");

  chk_ctrl_keeps_count: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && ctrlWrEn && !countWrEn && !preTick |=> $stable(count_r))
    else $error("control write changed count");

  chk_off_pre_hold: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && !ctrl_r.timerOnBit && !countWrEn && !onFall |=> $stable(pre_r))
    else $error("prescaler moved while disabled");

  sequence s_div8_steps;
    clkEn && preTick && !ctrlWrEn && ctrl_r.prescaleSelect == SIT_DIV8;
  endsequence
  chk_div8_spacing: assert property (@(posedge clk) disable iff (!arst_n)
    s_div8_steps ##1 (ctrlWrEn == 1'b0) [*1] |-> !preTick)
    else $error("divide-by-8 ticked twice in a row");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && flag_r && !flagClr |=> flag_r)
    else $error("match flag dropped without clear");

  chk_irq_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
    irqPulse |-> flag_r)
    else $error("interrupt without flag");
endmodule
`default_nettype wire

// File: bench/sit_pin_model.sv
// Source model for the external clock/gate pin.
// Assumes the pin idles low between frames and is driven, never released.
`timescale 1ns/10ps
`default_nettype none
module sit_pin_model (
  output logic pin
);
  initial pin = 1'b0;
  // Gate edges and the first pulse sit 3 ns after a falling bench clock edge; each further pulse shifts 3 ns; levels last over two cycles
  task automatic pulses(input int n);
    repeat (n)
    begin
      #33 pin = 1'b1;
      #30 pin = 1'b0;
    end
    #33;
  endtask
  task automatic gate(input int ns);
    #3 pin = 1'b1;
    #(ns) pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Bench for the interval timer: wrap, control writes, prescale, idle, sleep, gate.
// Assumes one 100 MHz clock; the pin model supplies external clock and gate.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sit_pkg::*;
  logic clk, arst_n, clkEn, ctrlWrEn, countWrEn, periodWrEn, flagClr, pin;
  logic periodMatchFlag, irqPulse;
  sit_ctrl_t ctrlWr, ctrlRd;
  logic [15:0] countWr, periodWr, countValue, periodValue, c;
  sit_power_t power;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  sit_timer u_sit_timer (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .ctrlWr(ctrlWr),
    .ctrlWrEn(ctrlWrEn), .countWr(countWr), .countWrEn(countWrEn), .periodWr(periodWr),
    .periodWrEn(periodWrEn), .flagClr(flagClr), .power(power),
    .externalClockGatePin(pin), .ctrlRd(ctrlRd), .countValue(countValue),
    .periodValue(periodValue), .periodMatchFlag(periodMatchFlag), .irqPulse(irqPulse));
  sit_pin_model u_sit_pin_model (.pin(pin));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The tests need about 900 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d, compares %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cfg(input logic on, idl, gt, input sit_prescale_t ps, input logic sy, cs);
    ctrlWr = '{on, idl, gt, ps, sy, cs};
    ctrlWrEn = 1'b1;
    @(negedge clk);
    ctrlWrEn = 1'b0;
  endtask
  task automatic wrc(input logic [15:0] v);
    countWr = v;
    countWrEn = 1'b1;
    @(negedge clk);
    countWrEn = 1'b0;
  endtask
  task automatic wrp(input logic [15:0] v);
    periodWr = v;
    periodWrEn = 1'b1;
    @(negedge clk);
    periodWrEn = 1'b0;
  endtask
  task automatic clrf();
    flagClr = 1'b1;
    @(negedge clk);
    flagClr = 1'b0;
  endtask
  task automatic ext(input int k);
    u_sit_pin_model.pulses(k);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_wrap();
    wrp(16'h0003);
    wrc(16'h0000);
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV1, 1'b0, 1'b0);
    n = 0;
    while (periodMatchFlag !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(countValue, 16'h0000);
    chk(16'(irqPulse), 16'h0001);
    @(negedge clk);
    chk(16'(periodMatchFlag), 16'h0001);
    clrf();
    chk(16'(periodMatchFlag), 16'h0000);
    wrp(16'hffff);
    wrc(16'h0000);
    c = countValue;
    cfg(1'b1, 1'b1, 1'b0, SIT_DIV1, 1'b0, 1'b0);
    chk(countValue, c + 16'h0001);
    $display("wrap and control test done");
  endtask
  task automatic t_pre();
    logic [15:0] ratio [4];
    ratio = '{16'h0001, 16'h0008, 16'h0040, 16'h0100};
    for (int i = 0; i < 4; i++)
    begin
      cfg(1'b1, 1'b0, 1'b0, sit_prescale_t'(i), 1'b0, 1'b0);
      wrc(16'h0000);
      n = 0;
      while (countValue !== 16'h0001 && n < 300)
      begin
        @(negedge clk);
        n++;
      end
      n = 0;
      while (countValue === 16'h0001 && n < 300)
      begin
        @(negedge clk);
        n++;
      end
      chk(16'(n), ratio[i]);
    end
    $display("prescale test done");
  endtask
  task automatic t_idle();
    cfg(1'b1, 1'b1, 1'b0, SIT_DIV1, 1'b0, 1'b0);
    power = '{1'b1, 1'b0};
    repeat (2) @(negedge clk);
    c = countValue;
    repeat (5) @(negedge clk);
    chk(countValue, c);
    power = '{1'b0, 1'b0};
    repeat (3) @(negedge clk);
    chk(countValue, c + 16'h0003);
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV1, 1'b0, 1'b0);
    power = '{1'b1, 1'b0};
    c = countValue;
    repeat (3) @(negedge clk);
    chk(countValue, c + 16'h0003);
    power = '{1'b0, 1'b0};
    $display("idle test done");
  endtask
  task automatic t_ext();
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV1, 1'b1, 1'b1);
    wrc(16'h0000);
    ext(4);
    chk(countValue, 16'h0004);
    power = '{1'b0, 1'b1};
    ext(2);
    chk(countValue, 16'h0004);
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV1, 1'b0, 1'b1);
    ext(3);
    chk(countValue, 16'h0007);
    power = '{1'b1, 1'b0};
    cfg(1'b1, 1'b1, 1'b0, SIT_DIV1, 1'b0, 1'b1);
    ext(2);
    chk(countValue, 16'h0007);
    power = '{1'b0, 1'b0};
    $display("external clock test done");
  endtask
  task automatic t_gate();
    cfg(1'b1, 1'b0, 1'b1, SIT_DIV1, 1'b0, 1'b0);
    wrc(16'h0000);
    clrf();
    repeat (3) @(negedge clk);
    chk(countValue, 16'h0000);
    u_sit_pin_model.gate(100);
    repeat (4) @(negedge clk);
    chk(countValue, 16'h000a);
    chk(16'(periodMatchFlag), 16'h0001);
    $display("gate test done");
  endtask
  // Turning the timer off mid-prescale must restart the divider from zero
  task automatic t_off();
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV8, 1'b0, 1'b0);
    wrc(16'h0000);
    repeat (3) @(negedge clk);
    cfg(1'b0, 1'b0, 1'b0, SIT_DIV8, 1'b0, 1'b0);
    c = countValue;
    repeat (10) @(negedge clk);
    chk(countValue, c);
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV8, 1'b0, 1'b0);
    n = 0;
    while (countValue === c && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'h0008);
    cfg(1'b1, 1'b0, 1'b0, SIT_DIV1, 1'b0, 1'b0);
    power = '{1'b0, 1'b1};
    repeat (2) @(negedge clk);
    c = countValue;
    repeat (4) @(negedge clk);
    chk(countValue, c);
    power = '{1'b0, 1'b0};
    $display("timer-off and sleep test done");
  endtask
  initial
  begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    ctrlWr = '0;
    ctrlWrEn = 1'b0;
    countWr = 16'h0000;
    countWrEn = 1'b0;
    periodWr = 16'h0000;
    periodWrEn = 1'b0;
    flagClr = 1'b0;
    power = '0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk(countValue, SIT_COUNT_RST);
    chk(periodValue, 16'hffff);
    chk(16'(ctrlRd), 16'h0000);
    $display("reset test done");
    t_wrap();
    t_pre();
    t_idle();
    t_ext();
    t_gate();
    t_off();
    stop_test();
  end
endmodule
`default_nettype wire
